// *** logic/acrs_consts.vh ***
// Constants for the converter input and reference selection block.
// Assumes a 50 MHz system clock and word-aligned Avalon-MM registers.
`ifndef ACRS_CONSTS_VH
`define ACRS_CONSTS_VH

// Register byte addresses (index times four)
`define ACRS_IDX_SEL         8'h07
`define ACRS_ADDR_SEL        8'h1c
`define ACRS_ADDR_ACTIVE     8'h20
`define ACRS_ADDR_STATUS     8'h24
`define ACRS_ADDR_MASK       8'h28
`define ACRS_ADDR_CTRL       8'h2c
`define ACRS_ADDR_RESULT     8'h30
`define ACRS_ADDR_SETTLE     8'h34

// Selection register fields
`define ACRS_REF_MSB         7
`define ACRS_REF_LSB         6
`define ACRS_CH_MSB          5
`define ACRS_CH_LSB          0
`define ACRS_SEL_RESET       8'h00

// Reference codes
`define ACRS_REF_SUPPLY      2'h0
`define ACRS_REF_EXTERNAL    2'h1
`define ACRS_REF_INTERNAL    2'h2
`define ACRS_REF_TO_PIN      2'h3

// Channel codes
`define ACRS_CH_SE_LAST      6'h07
`define ACRS_CH_DIFF_FIRST   6'h08
`define ACRS_CH_DIFF_LAST    6'h1f
`define ACRS_CH_GROUND       6'h20
`define ACRS_CH_IREF         6'h21
`define ACRS_CH_TEMP         6'h22
`define ACRS_CH_OFFS_FIRST   6'h23
`define ACRS_CH_OFFS_LAST    6'h27
`define ACRS_CH_REV_FIRST    6'h28

// Status bits
`define ACRS_ST_DONE         0
`define ACRS_ST_APPLIED      1
`define ACRS_ST_SETTLED      2
`define ACRS_ST_WIDTH        3

// Control bits
`define ACRS_CTRL_START      0

// Settling and conversion counts in converter clock cycles, and the divider reset value
`define ACRS_SETTLE_MIN      13
`define ACRS_SETTLE_MAX      25
`define ACRS_CONV_CYCLES     13
`define ACRS_DIV_RESET       8'h04

`endif

// *** logic/acrs_mux_decode.v ***
// Pure decode of the channel and reference fields into analog controls.
// Assumes the caller holds the fields stable; no state is kept here.
`include "acrs_consts.vh"
`default_nettype none

module acrs_mux_decode (
	input  wire [5:0] channel_gain_field,
	input  wire [1:0] ref_field,
	output reg  [7:0] pos_sel,
	output reg  [7:0] neg_sel,
	output reg        single_ended,
	output reg        differential,
	output reg        gain_20x,
	output reg        swapped,
	output reg        sel_ground,
	output reg        sel_iref,
	output reg        temp_sensor_en,
	output reg        offset_cal,
	output reg        ref_use_supply,
	output reg        ref_use_external,
	output reg        ref_int_on,
	output reg        ref_drive_pin
);
	reg [2:0] p_idx;
	reg [2:0] n_idx;
	reg [4:0] pair;

	always @* begin
		pos_sel        = 8'h00;
		neg_sel        = 8'h00;
		single_ended   = 1'b0;
		differential   = 1'b0;
		gain_20x       = 1'b0;
		swapped        = 1'b0;
		sel_ground     = 1'b0;
		sel_iref       = 1'b0;
		temp_sensor_en = 1'b0;
		offset_cal     = 1'b0;
		p_idx          = 3'h0;
		n_idx          = 3'h0;
		pair           = 5'h00;
		if (channel_gain_field <= `ACRS_CH_SE_LAST) begin
			single_ended = 1'b1;
			pos_sel[channel_gain_field[2:0]] = 1'b1;
		end else if (channel_gain_field == `ACRS_CH_GROUND) begin
			sel_ground = 1'b1;
		end else if (channel_gain_field == `ACRS_CH_IREF) begin
			sel_iref = 1'b1;
		end else if (channel_gain_field == `ACRS_CH_TEMP) begin
			temp_sensor_en = 1'b1;
			single_ended   = 1'b1;
		end else if (channel_gain_field >= `ACRS_CH_OFFS_FIRST &&
			channel_gain_field <= `ACRS_CH_OFFS_LAST) begin
			// Same input on both sides: inputs 0, 3 and 7 only
			offset_cal = 1'b1;
			gain_20x   = 1'b1;
			case (channel_gain_field[2:0])
			3'h3: p_idx = 3'h0;
			3'h5: p_idx = 3'h3;
			3'h7: p_idx = 3'h7;
			default: offset_cal = 1'b0;
			endcase
			if (offset_cal) begin
				pos_sel[p_idx] = 1'b1;
				neg_sel[p_idx] = 1'b1;
			end
		end else begin
			// Pair index from bits 4:1; neighbouring inputs form a pair
			differential = 1'b1;
			gain_20x     = channel_gain_field[0];
			swapped      = channel_gain_field[5];
			pair  = {1'b0, channel_gain_field[4:1]} - 5'h04;
			p_idx = pair[3:1];
			n_idx = pair[0] ? p_idx - 3'h1 : p_idx + 3'h1;
			if (swapped) begin
				pos_sel[n_idx] = 1'b1;
				neg_sel[p_idx] = 1'b1;
			end else begin
				pos_sel[p_idx] = 1'b1;
				neg_sel[n_idx] = 1'b1;
			end
		end
	end

	always @* begin
		ref_use_supply   = (ref_field == `ACRS_REF_SUPPLY);
		ref_use_external = (ref_field == `ACRS_REF_EXTERNAL);
		ref_int_on       = ref_field[1];
		ref_drive_pin    = (ref_field == `ACRS_REF_TO_PIN);
	end
endmodule

`default_nettype wire

// *** logic/acrs_settle_timer.v ***
// Counts converter clock enables after a differential or reference change.
// Assumes conv_tick is a one-cycle enable at the converter clock rate.
`include "acrs_consts.vh"
`default_nettype none

module acrs_settle_timer #(
	parameter MIN_CYCLES = `ACRS_SETTLE_MIN,
	parameter MAX_CYCLES = `ACRS_SETTLE_MAX
) (
	input  wire clk,
	input  wire arst_n,
	input  wire restart,
	input  wire conv_tick,
	output wire start_ok,
	output wire settled
);
	reg [4:0] count_reg;
	reg [4:0] count_next;

	always @* begin
		count_next = count_reg;
		if (restart)
			count_next = 5'h00;
		else if (conv_tick && count_reg != MAX_CYCLES[4:0])
			count_next = count_reg + 5'h01;
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			count_reg <= 5'h19;
		else
			count_reg <= count_next;
	end

	// Advisory only: software decides whether to wait or discard
	assign start_ok = (count_reg >= MIN_CYCLES[4:0]);
	assign settled  = (count_reg == MAX_CYCLES[4:0]);
endmodule

`default_nettype wire

// *** logic/acrs_top.v ***
// Input multiplexer and reference selection control with register slave.
// Assumes an Avalon-MM master on clk; conversion is a simple stand-in.
//
// Added by the designer: the Avalon-MM slave port.
`include "acrs_consts.vh"
`default_nettype none

module acrs_top #(
	parameter CONV_CYCLES = `ACRS_CONV_CYCLES,
	parameter DIV_WIDTH   = 8
) (
	input  wire        clk,
	input  wire        arst_n,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire [9:0]  conv_sample,
	output wire        irq,
	output wire        conv_busy,
	output wire [7:0]  pos_sel,
	output wire [7:0]  neg_sel,
	output wire        single_ended,
	output wire        differential,
	output wire        gain_20x,
	output wire        swapped,
	output wire        sel_ground,
	output wire        sel_iref,
	output wire        temp_sensor_en,
	output wire        offset_cal,
	output wire        ref_use_supply,
	output wire        ref_use_external,
	output wire        ref_int_on,
	output wire        ref_drive_pin,
	output wire        start_ok,
	output wire        settled
);
	localparam ST_IDLE = 2'b01;
	localparam ST_CONV = 2'b10;

	reg  [1:0]  state_reg;
	reg  [1:0]  state_next;
	reg  [7:0]  sel_reg;
	reg  [7:0]  active_reg;
	reg  [7:0]  active_next;
	reg  [2:0]  status_reg;
	reg  [2:0]  status_next;
	reg  [2:0]  mask_reg;
	reg  [7:0]  div_reg;
	reg  [DIV_WIDTH-1:0] tick_cnt_reg;
	reg  [4:0]  conv_cnt_reg;
	reg  [9:0]  result_reg;
	reg         ack_reg;
	reg         settled_d_reg;
	wire        conv_tick;
	wire        wr_hit;
	wire        rd_hit;
	wire        start_req;
	wire        conv_end;
	wire        restart;

	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	// Writes land only at the edge where waitrequest is low
	assign wr_hit    = avs_write && ack_reg;
	assign rd_hit    = avs_read && !ack_reg;
	assign conv_busy = state_reg[1];
	assign start_req = wr_hit && avs_address == `ACRS_ADDR_CTRL &&
		avs_byteenable[0] && avs_writedata[`ACRS_CTRL_START];
	assign conv_end  = conv_busy && conv_tick &&
		conv_cnt_reg == CONV_CYCLES[4:0] - 5'h01;

	// One-cycle answer: waitrequest drops on the second cycle of a request
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ack_reg <= 1'b0;
		else
			ack_reg <= (avs_read || avs_write) && !ack_reg;
	end

	// Converter clock enable from the system clock
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			tick_cnt_reg <= {DIV_WIDTH{1'b0}};
		else if (tick_cnt_reg >= div_reg[DIV_WIDTH-1:0])
			tick_cnt_reg <= {DIV_WIDTH{1'b0}};
		else
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
	end
	assign conv_tick = (tick_cnt_reg >= div_reg[DIV_WIDTH-1:0]);

	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE:
			if (start_req)
				state_next = ST_CONV;
		ST_CONV:
			if (conv_end)
				state_next = ST_IDLE;
		default:
			state_next = ST_IDLE;
		endcase
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg    <= ST_IDLE;
			conv_cnt_reg <= 5'h00;
			result_reg   <= 10'h000;
		end else begin
			state_reg <= state_next;
			if (!conv_busy)
				conv_cnt_reg <= 5'h00;
			else if (conv_tick)
				conv_cnt_reg <= conv_cnt_reg + 5'h01;
			if (conv_end)
				result_reg <= conv_sample;
		end
	end

	// Software copy stores at once; the active copy waits for idle
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			sel_reg <= `ACRS_SEL_RESET;
		else if (wr_hit && avs_address == `ACRS_ADDR_SEL &&
			avs_byteenable[0])
			sel_reg <= avs_writedata[7:0];
	end

	always @* begin
		active_next = active_reg;
		if (!conv_busy || conv_end)
			active_next = sel_reg;
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			active_reg <= `ACRS_SEL_RESET;
		else
			active_reg <= active_next;
	end

	wire next_is_diff;
	assign next_is_diff =
		active_next[`ACRS_CH_MSB:`ACRS_CH_LSB] >= `ACRS_CH_DIFF_FIRST &&
		(active_next[`ACRS_CH_MSB:`ACRS_CH_LSB] <= `ACRS_CH_DIFF_LAST ||
		active_next[`ACRS_CH_MSB:`ACRS_CH_LSB] >= `ACRS_CH_REV_FIRST);

	// Settling restarts on a new differential channel or reference
	assign restart = (active_next != active_reg) &&
		((active_next[`ACRS_CH_MSB:`ACRS_CH_LSB] !=
		active_reg[`ACRS_CH_MSB:`ACRS_CH_LSB] && next_is_diff) ||
		active_next[`ACRS_REF_MSB:`ACRS_REF_LSB] !=
		active_reg[`ACRS_REF_MSB:`ACRS_REF_LSB]);

	// Status: set wins over write-one-to-clear
	always @* begin
		status_next = status_reg;
		if (wr_hit && avs_address == `ACRS_ADDR_STATUS &&
			avs_byteenable[0])
			status_next = status_reg & ~avs_writedata[2:0];
		if (conv_end)
			status_next[`ACRS_ST_DONE] = 1'b1;
		if (conv_end && sel_reg != active_reg)
			status_next[`ACRS_ST_APPLIED] = 1'b1;
		if (settled && !settled_d_reg)
			status_next[`ACRS_ST_SETTLED] = 1'b1;
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_reg    <= 3'h0;
			mask_reg      <= 3'h0;
			div_reg       <= `ACRS_DIV_RESET;
			settled_d_reg <= 1'b1;
		end else begin
			status_reg    <= status_next;
			settled_d_reg <= settled;
			if (wr_hit && avs_address == `ACRS_ADDR_MASK &&
				avs_byteenable[0])
				mask_reg <= avs_writedata[2:0];
			if (wr_hit && avs_address == `ACRS_ADDR_SETTLE &&
				avs_byteenable[0])
				div_reg <= avs_writedata[7:0];
		end
	end

	assign irq = |(status_reg & mask_reg);

	// Unmapped addresses read zero and ignore writes
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			avs_readdata <= 32'h00000000;
		else if (rd_hit) begin
			case (avs_address)
			`ACRS_ADDR_SEL:    avs_readdata <= {24'h000000, sel_reg};
			`ACRS_ADDR_ACTIVE: avs_readdata <= {24'h000000, active_reg};
			`ACRS_ADDR_STATUS: avs_readdata <= {29'h0, status_reg};
			`ACRS_ADDR_MASK:   avs_readdata <= {29'h0, mask_reg};
			`ACRS_ADDR_CTRL:   avs_readdata <= {31'h0, conv_busy};
			`ACRS_ADDR_RESULT: avs_readdata <= {22'h0, result_reg};
			`ACRS_ADDR_SETTLE: avs_readdata <= {16'h0, 6'h00, settled,
				start_ok, div_reg};
			default:           avs_readdata <= 32'h00000000;
			endcase
		end
	end

	acrs_mux_decode u_decode (
		.channel_gain_field (active_reg[`ACRS_CH_MSB:`ACRS_CH_LSB]),
		.ref_field          (active_reg[`ACRS_REF_MSB:`ACRS_REF_LSB]),
		.pos_sel            (pos_sel),
		.neg_sel            (neg_sel),
		.single_ended       (single_ended),
		.differential       (differential),
		.gain_20x           (gain_20x),
		.swapped            (swapped),
		.sel_ground         (sel_ground),
		.sel_iref           (sel_iref),
		.temp_sensor_en     (temp_sensor_en),
		.offset_cal         (offset_cal),
		.ref_use_supply     (ref_use_supply),
		.ref_use_external   (ref_use_external),
		.ref_int_on         (ref_int_on),
		.ref_drive_pin      (ref_drive_pin)
	);

	acrs_settle_timer u_settle (
		.clk       (clk),
		.arst_n    (arst_n),
		.restart   (restart),
		.conv_tick (conv_tick),
		.start_ok  (start_ok),
		.settled   (settled)
	);
endmodule

`default_nettype wire

// *** test/acrs_props.sv ***
// Checker for the selection block, bound to the top module's ports.
// Assumes the register bus holds write data until waitrequest drops.
`include "acrs_consts.vh"
`default_nettype none

module acrs_chk (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        conv_busy,
	input wire logic [7:0]  pos_sel,
	input wire logic [7:0]  neg_sel,
	input wire logic        single_ended,
	input wire logic        differential,
	input wire logic        gain_20x,
	input wire logic        swapped,
	input wire logic        sel_ground,
	input wire logic        sel_iref,
	input wire logic        temp_sensor_en,
	input wire logic        offset_cal,
	input wire logic        ref_use_supply,
	input wire logic        ref_use_external,
	input wire logic        ref_int_on,
	input wire logic        ref_drive_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Idle write to the selection register, taken at this edge
	wire idle_wr = avs_write && !avs_waitrequest && !conv_busy &&
		avs_address == `ACRS_ADDR_SEL && avs_byteenable[0];

	temp_path_a: assert property (
		temp_sensor_en |-> single_ended && !differential)
		else $error("temperature path not single-ended");
	ref_int_a: assert property (
		idle_wr && avs_writedata[7:6] == `ACRS_REF_INTERNAL |-> ##2
		ref_int_on && !ref_use_supply && !ref_use_external && !ref_drive_pin)
		else $error("internal reference not selected");
	ext_ref_a: assert property (
		ref_use_external |-> !ref_int_on && !ref_drive_pin)
		else $error("internal reference on with external pin");
	pin_drive_a: assert property (
		ref_drive_pin |-> ref_int_on && !ref_use_external)
		else $error("pin driven without internal reference");
	busy_hold_a: assert property (
		$past(conv_busy) && conv_busy |->
		$stable({pos_sel, neg_sel, ref_int_on, ref_use_external})
		) else $error("selection changed during conversion");
	single_sel_a: assert property (
		idle_wr && avs_writedata[5:3] == 3'h0 |-> ##2 single_ended &&
		pos_sel == (8'h01 << $past(avs_writedata[2:0], 2)))
		else $error("single input not selected");
	diff_sel_a: assert property (
		idle_wr && avs_writedata[4:3] != 2'h0 |-> ##2 differential &&
		gain_20x == $past(avs_writedata[0], 2) &&
		swapped == $past(avs_writedata[5], 2))
		else $error("differential decode wrong");
	offs_same_a: assert property (
		offset_cal |-> pos_sel == neg_sel &&
		(pos_sel == 8'h01 || pos_sel == 8'h08 || pos_sel == 8'h80))
		else $error("offset calibration inputs wrong");
	ground_sel_a: assert property (
		sel_ground |-> !sel_iref && !temp_sensor_en && !differential)
		else $error("ground selection mixed");
endmodule

bind acrs_top acrs_chk i_chk (
	.clk              (clk),
	.arst_n           (arst_n),
	.avs_address      (avs_address),
	.avs_write        (avs_write),
	.avs_waitrequest  (avs_waitrequest),
	.avs_writedata    (avs_writedata),
	.avs_byteenable   (avs_byteenable),
	.conv_busy        (conv_busy),
	.pos_sel          (pos_sel),
	.neg_sel          (neg_sel),
	.single_ended     (single_ended),
	.differential     (differential),
	.gain_20x         (gain_20x),
	.swapped          (swapped),
	.sel_ground       (sel_ground),
	.sel_iref         (sel_iref),
	.temp_sensor_en   (temp_sensor_en),
	.offset_cal       (offset_cal),
	.ref_use_supply   (ref_use_supply),
	.ref_use_external (ref_use_external),
	.ref_int_on       (ref_int_on),
	.ref_drive_pin    (ref_drive_pin)
);
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the selection block over Avalon-MM.
// Assumes the top runs at 50 MHz; the divider keeps its reset setting until the settling test sets it to 0.
`include "acrs_consts.vh"
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, arst_n, avs_read, avs_write, avs_waitrequest, irq;
	logic [7:0]  avs_address, pos_sel, neg_sel, p, n;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0]  avs_byteenable;
	logic [9:0]  conv_sample;
	logic        conv_busy, single_ended, differential, gain_20x, swapped;
	logic        sel_ground, sel_iref, temp_sensor_en, offset_cal, start_ok;
	logic        ref_use_supply, ref_use_external, ref_int_on, ref_drive_pin;
	logic        settled;
	int          bad_count, samples_checked, cycles, i;

	acrs_top #(.CONV_CYCLES(13)) i_acrs_top (
		.clk              (clk),
		.arst_n           (arst_n),
		.avs_address      (avs_address),
		.avs_read         (avs_read),
		.avs_write        (avs_write),
		.avs_writedata    (avs_writedata),
		.avs_byteenable   (avs_byteenable),
		.avs_readdata     (avs_readdata),
		.avs_waitrequest  (avs_waitrequest),
		.conv_sample      (conv_sample),
		.irq              (irq),
		.conv_busy        (conv_busy),
		.pos_sel          (pos_sel),
		.neg_sel          (neg_sel),
		.single_ended     (single_ended),
		.differential     (differential),
		.gain_20x         (gain_20x),
		.swapped          (swapped),
		.sel_ground       (sel_ground),
		.sel_iref         (sel_iref),
		.temp_sensor_en   (temp_sensor_en),
		.offset_cal       (offset_cal),
		.ref_use_supply   (ref_use_supply),
		.ref_use_external (ref_use_external),
		.ref_int_on       (ref_int_on),
		.ref_drive_pin    (ref_drive_pin),
		.start_ok         (start_ok),
		.settled          (settled)
	);

	always #10 clk = ~clk;

	task chk(input string what, input logic [31:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	task rdr(input logic [7:0] a);
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
	endtask

	// Selection write, then let the active selection settle
	task sel(input logic [7:0] v);
		wr(`ACRS_ADDR_SEL, {24'h0, v});
		repeat (2) @(posedge clk);
		#1;
	endtask

	task t_reset;
		rdr(`ACRS_ADDR_SEL);
		chk("sel reg", 0, rd);
		chk("pos reset", 1, pos_sel);
		chk("supply reset", 1, ref_use_supply);
		chk("settle reset", 2'b11, {start_ok, settled});
		rdr(8'h3c);
		chk("unmapped", 0, rd);
		// Lane 0 off: the write must leave the selection alone
		avs_byteenable <= 4'he;
		wr(`ACRS_ADDR_SEL, 32'h3f);
		avs_byteenable <= 4'hf;
		rdr(`ACRS_ADDR_SEL);
		chk("lane off", 0, rd);
		$display("reset test done");
	endtask

	task t_single;
		for (i = 0; i < 8; i++) begin
			sel(i[7:0]);
			chk("single pos", 1 << i, pos_sel);
			chk("single mode", 2'b10, {single_ended, differential});
		end
		sel(8'h20);
		chk("ground", 2'b10, {sel_ground, sel_iref});
		sel(8'h21);
		chk("iref", 2'b01, {sel_ground, sel_iref});
		$display("single test done");
	endtask

	task t_ref;
		logic [3:0] exp [4] = '{4'h8, 4'h4, 4'h2, 4'h3};
		for (i = 0; i < 4; i++) begin
			sel({i[1:0], 6'h22});
			chk("ref", exp[i], {ref_use_supply, ref_use_external,
				ref_int_on, ref_drive_pin});
			chk("temp", 2'b11, {temp_sensor_en, single_ended});
		end
		$display("reference test done");
	endtask

	task t_diff;
		sel(8'h08);
		chk("diff", 3'b100, {differential, gain_20x, swapped});
		p = pos_sel;
		n = neg_sel;
		sel(8'h09);
		chk("gain", 3'b110, {differential, gain_20x, swapped});
		chk("gain pair", {p, n}, {pos_sel, neg_sel});
		sel(8'h28);
		chk("rev", 3'b101, {differential, gain_20x, swapped});
		chk("rev pair", {n, p}, {pos_sel, neg_sel});
		sel(8'h3f);
		chk("rev top", 3'b111, {differential, gain_20x, swapped});
		$display("differential test done");
	endtask

	task t_offs;
		logic [7:0] pin [3] = '{8'h01, 8'h08, 8'h80};
		for (i = 0; i < 3; i++) begin
			sel(8'(8'h23 + 2 * i));
			chk("offs", {1'b1, pin[i], pin[i]},
				{offset_cal, pos_sel, neg_sel});
		end
		sel(8'h24);
		chk("offs unused", 0, offset_cal);
		$display("offset test done");
	endtask

	// Temperature channel with internal reference, then a change in flight
	task t_defer;
		wr(`ACRS_ADDR_MASK, 0);
		sel(8'ha2);
		wr(`ACRS_ADDR_STATUS, 32'h7);
		wr(`ACRS_ADDR_CTRL, 32'h1);
		rdr(`ACRS_ADDR_CTRL);
		chk("busy flag", 1, rd[0]);
		sel(8'h01);
		chk("busy temp", 1, temp_sensor_en);
		chk("busy ref", 1, ref_int_on);
		rdr(`ACRS_ADDR_ACTIVE);
		chk("busy active", 8'ha2, rd[7:0]);
		chk("irq masked", 0, irq);
		for (i = 0; i < 400 && conv_busy !== 1'b0; i++) @(posedge clk);
		chk("conv end", 0, conv_busy);
		repeat (2) @(posedge clk);
		#1;
		chk("after pos", 8'h02, pos_sel);
		chk("after ref", 1, ref_use_supply);
		rdr(`ACRS_ADDR_STATUS);
		chk("status", 2'b11, rd[1:0]);
		rdr(`ACRS_ADDR_RESULT);
		chk("result", 10'h2a5, (rd[9:8] << 8) | rd[7:0]);
		wr(`ACRS_ADDR_MASK, 32'h1);
		#1;
		chk("irq on", 1, irq);
		wr(`ACRS_ADDR_STATUS, 32'h1);
		#1;
		chk("irq off", 0, irq);
		$display("deferred change test done");
	endtask

	// Divider 0: one converter tick per clock, so edges count ticks
	task t_settle;
		wr(`ACRS_ADDR_SETTLE, 0);
		sel(8'h08);
		chk("settle start", 2'b00, {start_ok, settled});
		wr(`ACRS_ADDR_STATUS, 32'h7);
		rdr(`ACRS_ADDR_STATUS);
		chk("settle clear", 0, rd[2]);
		repeat (5) @(posedge clk);
		#1;
		chk("early start", 0, start_ok);
		@(posedge clk);
		#1;
		chk("start ok", 2'b10, {start_ok, settled});
		repeat (11) @(posedge clk);
		#1;
		chk("not settled", 0, settled);
		@(posedge clk);
		#1;
		chk("settled", 1, settled);
		rdr(`ACRS_ADDR_STATUS);
		chk("settle flag", 1, rd[2]);
		rdr(`ACRS_ADDR_SETTLE);
		chk("settle reg", 32'h300, rd);
		sel(8'h48);
		chk("ref restart", 2'b00, {start_ok, settled});
		$display("settling test done");
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Hang guard, far above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			end_sim();
		end
	end

	initial begin
		clk = 0;
		arst_n = 0;
		avs_read = 0;
		avs_write = 0;
		avs_address = 0;
		avs_writedata = 0;
		avs_byteenable = 4'hf;
		conv_sample = 10'h2a5;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_single();
		t_ref();
		t_diff();
		t_offs();
		t_defer();
		t_settle();
		end_sim();
	end
endmodule
`default_nettype wire
